// >>> src/geir_consts.vh
`ifndef GEIR_CONSTS_VH
`define GEIR_CONSTS_VH

// Interruption-information layout
`define GEIR_VEC_LO        0
`define GEIR_VEC_HI        7
`define GEIR_TYPE_LO       8
`define GEIR_TYPE_HI       10
`define GEIR_ERRV_BIT      11
`define GEIR_UNBLK_BIT     12
`define GEIR_VALID_BIT     31
`define GEIR_RSVD_W        18

// Interruption types
`define GEIR_T_EXT         3'h0
`define GEIR_T_NMI         3'h2
`define GEIR_T_HW          3'h3
`define GEIR_T_SWINT       3'h4
`define GEIR_T_PRIVSW      3'h5
`define GEIR_T_SW          3'h6

// Instruction-information layout
`define GEIR_II_RSVD2_W    1
`define GEIR_II_RSVD14_W   4

// Read select codes
`define GEIR_SEL_W         4
`define GEIR_SEL_EXIT_INFO 4'h0
`define GEIR_SEL_EXIT_ERR  4'h1
`define GEIR_SEL_VEC_INFO  4'h2
`define GEIR_SEL_VEC_ERR   4'h3
`define GEIR_SEL_INSN_LEN  4'h4
`define GEIR_SEL_LIN_ADDR  4'h5
`define GEIR_SEL_INSN_INFO 4'h6
`define GEIR_SEL_IO_COUNT  4'h7
`define GEIR_SEL_IO_SRC    4'h8
`define GEIR_SEL_IO_DST    4'h9
`define GEIR_SEL_IO_PTR    4'hA
`define GEIR_SEL_INSN_ERR  4'hB

// Snapshot register indexes
`define GEIR_SNAP_N        4
`define GEIR_SNAP_COUNT    0
`define GEIR_SNAP_SRC      1
`define GEIR_SNAP_DST      2
`define GEIR_SNAP_PTR      3

`define GEIR_ZERO32        32'h00000000
`define GEIR_ZERO64        64'h0000000000000000

`endif

// >>> src/geir_recorder.v
`timescale 1ns/1ps
`default_nettype none
`include "geir_consts.vh"

module geir_recorder (
	input  wire        clk,
	input  wire        reset,
	input  wire        exit_strobe,
	input  wire        exit_by_event,
	input  wire        ack_intr_on_exit,
	input  wire [7:0]  event_vector,
	input  wire [2:0]  event_type,
	input  wire        event_has_err,
	input  wire [31:0] event_err_code,
	input  wire        nmi_unblock_interrupt_return_instr,
	input  wire        delivering,
	input  wire [7:0]  dlv_vector,
	input  wire [2:0]  dlv_type,
	input  wire        dlv_has_err,
	input  wire [31:0] dlv_err_code,
	input  wire        exit_by_instr,
	input  wire [31:0] instr_length,
	input  wire        lin_addr_used,
	input  wire [63:0] lin_addr,
	input  wire        virt_instr_exit,
	input  wire        virt_instr_mem_only,
	input  wire [1:0]  scaling,
	input  wire [3:0]  first_reg_operand,
	input  wire [2:0]  addr_size,
	input  wire        operand_is_reg,
	input  wire [2:0]  seg_reg,
	input  wire [3:0]  index_reg_operand,
	input  wire        no_index,
	input  wire [3:0]  base_reg_operand,
	input  wire        no_base,
	input  wire [3:0]  second_reg_operand,
	input  wire        smi_after_io,
	input  wire [63:0] pre_count_register,
	input  wire [63:0] pre_source_index_register,
	input  wire [63:0] pre_dest_index_register,
	input  wire [63:0] pre_instruction_pointer,
	input  wire        instr_err_strobe,
	input  wire [31:0] instr_err_code,
	input  wire        rd_strobe,
	input  wire [3:0]  rd_sel,
	input  wire        wr_strobe,
	output reg         exit_done_ff,
	output reg         rd_valid_ff,
	output reg  [63:0] rd_data_ff,
	output reg         wr_fail_ff
);

	reg [31:0] exit_info_ff;
	reg [31:0] exit_err_ff;
	reg [31:0] vec_info_ff;
	reg [31:0] vec_err_ff;
	reg [31:0] insn_len_ff;
	reg [63:0] lin_addr_ff;
	reg [31:0] insn_info_ff;
	reg [63:0] io_snap_ff [0:`GEIR_SNAP_N-1];
	reg [31:0] insn_err_ff;

	// Builds an info record; reserved bits 30:13 always zero
	function [31:0] info_word;
		input [7:0] vec;
		input [2:0] typ;
		input       errv;
		input       bit12;
		begin
			info_word = `GEIR_ZERO32;
			info_word[`GEIR_VEC_HI:`GEIR_VEC_LO]   = vec;
			info_word[`GEIR_TYPE_HI:`GEIR_TYPE_LO] = typ;
			info_word[`GEIR_ERRV_BIT]              = errv;
			info_word[`GEIR_UNBLK_BIT]             = bit12;
			info_word[`GEIR_VALID_BIT]             = 1'b1;
		end
	endfunction

	// Types that an exit itself may report
	function exit_type_ok;
		input [2:0] typ;
		begin
			case (typ)
				`GEIR_T_EXT: exit_type_ok = 1'b1;
				`GEIR_T_NMI: exit_type_ok = 1'b1;
				`GEIR_T_HW:  exit_type_ok = 1'b1;
				`GEIR_T_SW:  exit_type_ok = 1'b1;
				default:     exit_type_ok = 1'b0;
			endcase
		end
	endfunction

	function is_sw_event;
		input [2:0] typ;
		begin
			case (typ)
				`GEIR_T_SWINT:  is_sw_event = 1'b1;
				`GEIR_T_PRIVSW: is_sw_event = 1'b1;
				`GEIR_T_SW:     is_sw_event = 1'b1;
				default:        is_sw_event = 1'b0;
			endcase
		end
	endfunction

	// Types that a record of interrupted delivery may carry
	function vec_type_ok;
		input [2:0] typ;
		begin
			case (typ)
				`GEIR_T_SWINT:  vec_type_ok = 1'b1;
				`GEIR_T_PRIVSW: vec_type_ok = 1'b1;
				default:        vec_type_ok = exit_type_ok(typ);
			endcase
		end
	endfunction

	// 32-bit fields read back zero-extended into the 64-bit data path
	function [63:0] widen32;
		input [31:0] word;
		begin
			widen32 = {`GEIR_ZERO32, word};
		end
	endfunction

	// Exit-side qualifiers, all sampled in the strobe cycle
	// External interrupts count only when they are acknowledged on exit
	wire ext_ok = (event_type != `GEIR_T_EXT) || ack_intr_on_exit;
	wire rec_exit = exit_strobe && exit_by_event && ext_ok && exit_type_ok(event_type);
	wire exit_errv = event_has_err && (event_type == `GEIR_T_HW);
	wire dlv_type_ok = vec_type_ok(dlv_type);
	wire rec_vec = exit_strobe && delivering && dlv_type_ok;
	wire dlv_errv = dlv_has_err && (dlv_type == `GEIR_T_HW);
	wire len_used = exit_by_instr || (delivering && is_sw_event(dlv_type));
	wire mem_bit = operand_is_reg && !virt_instr_mem_only;

	// Instruction information, top field first; undefined fields pass inputs through
	// Reserved bits 14:11 and 2 are driven as zero
	wire [31:0] insn_word = {
		second_reg_operand,
		no_base,
		base_reg_operand,
		no_index,
		index_reg_operand,
		seg_reg,
		{`GEIR_II_RSVD14_W{1'b0}},
		mem_bit,
		addr_size,
		first_reg_operand,
		{`GEIR_II_RSVD2_W{1'b0}},
		scaling
	};

	// Snapshot inputs gathered so that one loop captures them all
	wire [63:0] io_pre [0:`GEIR_SNAP_N-1];
	assign io_pre[`GEIR_SNAP_COUNT] = pre_count_register;
	assign io_pre[`GEIR_SNAP_SRC]   = pre_source_index_register;
	assign io_pre[`GEIR_SNAP_DST]   = pre_dest_index_register;
	assign io_pre[`GEIR_SNAP_PTR]   = pre_instruction_pointer;

	// Next values; the whole record for one exit commits at a single edge
	reg [31:0] nxt_exit_info;
	reg [31:0] nxt_exit_err;
	reg [31:0] nxt_vec_info;
	reg [31:0] nxt_vec_err;
	reg [31:0] nxt_insn_len;
	reg [63:0] nxt_lin_addr;
	reg [31:0] nxt_insn_info;
	reg [31:0] nxt_insn_err;

	always @*
	begin
		nxt_exit_info = exit_info_ff;
		nxt_exit_err  = exit_err_ff;
		nxt_vec_info  = vec_info_ff;
		nxt_vec_err   = vec_err_ff;
		nxt_insn_len  = insn_len_ff;
		nxt_lin_addr  = lin_addr_ff;
		nxt_insn_info = insn_info_ff;
		if (exit_strobe)
		begin
			if (rec_exit)
				nxt_exit_info = info_word(event_vector, event_type, exit_errv,
					nmi_unblock_interrupt_return_instr);
			else
				nxt_exit_info = `GEIR_ZERO32;
			// Without a valid code the previous one is kept, not cleared
			if (rec_exit && exit_errv)
				nxt_exit_err = event_err_code;
			// Bit 12 has no meaning here, so it is held at zero
			if (rec_vec)
				nxt_vec_info = info_word(dlv_vector, dlv_type, dlv_errv, 1'b0);
			else
				nxt_vec_info = `GEIR_ZERO32;
			if (rec_vec && dlv_errv)
				nxt_vec_err = dlv_err_code;
			if (len_used)
				nxt_insn_len = instr_length;
			if (lin_addr_used)
				nxt_lin_addr = lin_addr;
			if (virt_instr_exit)
				nxt_insn_info = insn_word;
		end
	end

	// The error field belongs to instruction execution; exits never touch it
	always @*
	begin
		nxt_insn_err = insn_err_ff;
		if (instr_err_strobe)
			nxt_insn_err = instr_err_code;
	end

	// Done follows the edge that commits the whole record
	always @(posedge clk)
	begin
		if (reset)
			exit_done_ff <= 1'b0;
		else
			exit_done_ff <= exit_strobe;
	end

	always @(posedge clk)
	begin
		if (reset)
			exit_info_ff <= `GEIR_ZERO32;
		else
			exit_info_ff <= nxt_exit_info;
	end

	always @(posedge clk)
	begin
		if (reset)
			exit_err_ff <= `GEIR_ZERO32;
		else
			exit_err_ff <= nxt_exit_err;
	end

	always @(posedge clk)
	begin
		if (reset)
			vec_info_ff <= `GEIR_ZERO32;
		else
			vec_info_ff <= nxt_vec_info;
	end

	always @(posedge clk)
	begin
		if (reset)
			vec_err_ff <= `GEIR_ZERO32;
		else
			vec_err_ff <= nxt_vec_err;
	end

	always @(posedge clk)
	begin
		if (reset)
			insn_len_ff <= `GEIR_ZERO32;
		else
			insn_len_ff <= nxt_insn_len;
	end

	always @(posedge clk)
	begin
		if (reset)
			lin_addr_ff <= `GEIR_ZERO64;
		else
			lin_addr_ff <= nxt_lin_addr;
	end

	always @(posedge clk)
	begin
		if (reset)
			insn_info_ff <= `GEIR_ZERO32;
		else
			insn_info_ff <= nxt_insn_info;
	end

	always @(posedge clk)
	begin
		if (reset)
			insn_err_ff <= `GEIR_ZERO32;
		else
			insn_err_ff <= nxt_insn_err;
	end

	// Snapshots only for a system-management exit right after an I/O instruction
	integer k;
	always @(posedge clk)
	begin
		for (k = 0; k < `GEIR_SNAP_N; k = k + 1)
		begin
			if (reset)
				io_snap_ff[k] <= `GEIR_ZERO64;
			else if (exit_strobe && smi_after_io)
				io_snap_ff[k] <= io_pre[k];
		end
	end

	reg [63:0] nxt_rd_data;

	// Reads in the exit cycle still return the previous record
	// Unmapped selects are answered with zero rather than ignored
	always @*
	begin
		nxt_rd_data = `GEIR_ZERO64;
		case (rd_sel)
			`GEIR_SEL_EXIT_INFO: nxt_rd_data = widen32(exit_info_ff);
			`GEIR_SEL_EXIT_ERR:  nxt_rd_data = widen32(exit_err_ff);
			`GEIR_SEL_VEC_INFO:  nxt_rd_data = widen32(vec_info_ff);
			`GEIR_SEL_VEC_ERR:   nxt_rd_data = widen32(vec_err_ff);
			`GEIR_SEL_INSN_LEN:  nxt_rd_data = widen32(insn_len_ff);
			`GEIR_SEL_LIN_ADDR:  nxt_rd_data = lin_addr_ff;
			`GEIR_SEL_INSN_INFO: nxt_rd_data = widen32(insn_info_ff);
			`GEIR_SEL_IO_COUNT:  nxt_rd_data = io_snap_ff[`GEIR_SNAP_COUNT];
			`GEIR_SEL_IO_SRC:    nxt_rd_data = io_snap_ff[`GEIR_SNAP_SRC];
			`GEIR_SEL_IO_DST:    nxt_rd_data = io_snap_ff[`GEIR_SNAP_DST];
			`GEIR_SEL_IO_PTR:    nxt_rd_data = io_snap_ff[`GEIR_SNAP_PTR];
			`GEIR_SEL_INSN_ERR:  nxt_rd_data = widen32(insn_err_ff);
			default:             nxt_rd_data = `GEIR_ZERO64;
		endcase
	end

	// Read answer stands for the one cycle after the strobe; data is zero otherwise
	always @(posedge clk)
	begin
		if (reset)
			rd_valid_ff <= 1'b0;
		else
			rd_valid_ff <= rd_strobe;
	end

	always @(posedge clk)
	begin
		if (reset)
			rd_data_ff <= `GEIR_ZERO64;
		else
			rd_data_ff <= rd_strobe ? nxt_rd_data : `GEIR_ZERO64;
	end

	// Any write attempt is refused; no field changes
	always @(posedge clk)
	begin
		if (reset)
			wr_fail_ff <= 1'b0;
		else
			wr_fail_ff <= wr_strobe;
	end

endmodule
`default_nettype wire

// >>> test/geir_props.sv
`timescale 1ns/1ps
`default_nettype none
module geir_props (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        exit_strobe,
	input wire logic        rd_strobe,
	input wire logic        wr_strobe,
	input wire logic [3:0]  rd_sel,
	input wire logic        exit_done_ff,
	input wire logic        rd_valid_ff,
	input wire logic [63:0] rd_data_ff,
	input wire logic        wr_fail_ff
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	a_done_after_exit: assert property (exit_strobe |=> exit_done_ff)
		else $error("exit not completed");
	a_done_has_cause: assert property (exit_done_ff |-> $past(exit_strobe))
		else $error("done without exit");
	a_read_answered: assert property (rd_strobe |=> rd_valid_ff)
		else $error("read not answered");
	a_write_refused: assert property (wr_strobe |=> wr_fail_ff)
		else $error("write not refused");
	a_idle_data_zero: assert property (!rd_valid_ff |-> rd_data_ff == 64'h0)
		else $error("data outside read");
	a_narrow_upper_zero: assert property (rd_valid_ff
		&& !($past(rd_sel) inside {4'h5, 4'h7, 4'h8, 4'h9, 4'hA})
		|-> rd_data_ff[63:32] == 32'h0)
		else $error("narrow field upper bits set");
	a_info_reserved_zero: assert property (rd_valid_ff && $past(rd_sel) inside {4'h0, 4'h2}
		|-> rd_data_ff[30:13] == 18'h0)
		else $error("reserved info bits set");
	a_exit_type_legal: assert property (rd_valid_ff && $past(rd_sel) == 4'h0
		|-> rd_data_ff[10:8] inside {3'h0, 3'h2, 3'h3, 3'h6})
		else $error("illegal exit type");
endmodule
bind geir_recorder geir_props u_props (.clk, .reset, .exit_strobe, .rd_strobe, .wr_strobe,
	.rd_sel, .exit_done_ff, .rd_valid_ff, .rd_data_ff, .wr_fail_ff);
`default_nettype wire

// >>> test/geir_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module geir_core_model (
	input  wire logic        clk,
	output wire logic [63:0] pre_count_register,
	output wire logic [63:0] pre_source_index_register,
	output wire logic [63:0] pre_dest_index_register,
	output wire logic [63:0] pre_instruction_pointer
);
	logic [31:0] step_ff = 32'h0;
	// Values move every cycle so a capture on the wrong edge cannot pass
	always @(posedge clk)
		step_ff <= step_ff + 32'h1;
	assign pre_count_register        = {32'h11110000, step_ff};
	assign pre_source_index_register = {32'h22220000, ~step_ff};
	assign pre_dest_index_register   = {step_ff, 32'h33330000};
	assign pre_instruction_pointer   = {~step_ff, 32'h44440000};
endmodule
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk, reset, exit_strobe, exit_by_event, ack_intr_on_exit, event_has_err;
	logic        nmi_unblock_interrupt_return_instr, delivering, dlv_has_err, exit_by_instr, lin_addr_used;
	logic        virt_instr_exit, virt_instr_mem_only, operand_is_reg, no_index, no_base;
	logic        smi_after_io, instr_err_strobe, rd_strobe, wr_strobe;
	logic        exit_done_ff, rd_valid_ff, wr_fail_ff;
	logic [1:0]  scaling;
	logic [2:0]  event_type, dlv_type, addr_size, seg_reg;
	logic [3:0]  first_reg_operand, index_reg_operand, base_reg_operand, second_reg_operand, rd_sel;
	logic [7:0]  event_vector, dlv_vector;
	logic [31:0] event_err_code, dlv_err_code, instr_length, instr_err_code;
	logic [63:0] lin_addr, rd_data_ff, pre_count_register, pre_source_index_register;
	logic [63:0] pre_dest_index_register, pre_instruction_pointer, len_exp;
	logic [63:0] snap [4];
	int          err_count = 0;
	int          checked = 0;
	geir_recorder DUT (.*);
	geir_core_model core (.*);
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic complete_run;
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [3:0] sel, input logic [63:0] exp);
		@(negedge clk);
		{rd_strobe, rd_sel} = {1'b1, sel};
		@(negedge clk);
		rd_strobe = 1'b0;
		chk({63'h0, rd_valid_ff}, 64'h1);
		chk(rd_data_ff, exp);
	endtask
	task automatic do_exit;
		@(negedge clk);
		exit_strobe = 1'b1;
		snap = '{pre_count_register, pre_source_index_register, pre_dest_index_register,
			pre_instruction_pointer};
		@(negedge clk);
		exit_strobe = 1'b0;
		chk({63'h0, exit_done_ff}, 64'h1);
	endtask
	initial
	begin
		repeat (5000) @(posedge clk);
		err_count++;
		complete_run;
	end
	initial
	begin
		{exit_strobe, exit_by_event, ack_intr_on_exit, event_vector, event_type, event_has_err,
			event_err_code, nmi_unblock_interrupt_return_instr, delivering, dlv_vector, dlv_type, dlv_has_err,
			dlv_err_code, exit_by_instr, instr_length, lin_addr_used, lin_addr, virt_instr_exit,
			virt_instr_mem_only, scaling, first_reg_operand, addr_size, operand_is_reg, seg_reg,
			index_reg_operand, no_index, base_reg_operand, no_base, second_reg_operand,
			smi_after_io, instr_err_strobe, instr_err_code, rd_strobe, rd_sel, wr_strobe} = '0;
		reset = 1'b1;
		len_exp = 64'h0;
		repeat (20) @(negedge clk);
		reset = 1'b0;
		for (int s = 0; s < 16; s++) rd(s[3:0], 64'h0);
		{instr_err_strobe, instr_err_code} = {1'b1, 32'h0000000C};
		@(negedge clk);
		instr_err_strobe = 1'b0;
		{exit_by_event, event_type, event_vector, event_has_err, event_err_code, nmi_unblock_interrupt_return_instr,
			ack_intr_on_exit} = {1'b1, 3'h3, 8'h0E, 1'b1, 32'hA5A50011, 1'b1, 1'b1};
		{delivering, dlv_type, dlv_vector, dlv_has_err, dlv_err_code} =
			{1'b1, 3'h3, 8'h0D, 1'b1, 32'h5A5A0022};
		do_exit;
		rd(4'h0, 64'h80001B0E);
		rd(4'h1, 64'hA5A50011);
		rd(4'h2, 64'h80000B0D);
		rd(4'h3, 64'h5A5A0022);
		// Error flags off: the stored codes must survive every pass
		for (int t = 0; t < 8; t++)
		begin
			{event_type, event_vector, event_has_err, nmi_unblock_interrupt_return_instr} =
				{t[2:0], 5'h04, t[2:0], 2'b00};
			{dlv_type, dlv_vector, dlv_has_err, instr_length} =
				{t[2:0], 5'h05, t[2:0], 1'b0, 32'h10 + t};
			if (t >= 4 && t <= 6)
				len_exp = 64'h10 + t;
			do_exit;
			rd(4'h0, (t inside {0, 2, 3, 6}) ? {33'h1, 20'h0, t[2:0], 5'h04, t[2:0]} : 64'h0);
			rd(4'h2, (t != 1 && t != 7) ? {33'h1, 20'h0, t[2:0], 5'h05, t[2:0]} : 64'h0);
			rd(4'h4, len_exp);
		end
		rd(4'h1, 64'hA5A50011);
		rd(4'h3, 64'h5A5A0022);
		{event_type, ack_intr_on_exit} = {3'h3, 1'b1};
		do_exit;
		{event_type, ack_intr_on_exit} = {3'h0, 1'b0};
		do_exit;
		rd(4'h0, 64'h0);
		{exit_by_event, delivering, exit_by_instr, instr_length, lin_addr_used, lin_addr} =
			{2'b00, 1'b1, 32'h0000000F, 1'b1, 64'hFEDCBA9876543210};
		{virt_instr_exit, virt_instr_mem_only, operand_is_reg, scaling, first_reg_operand,
			addr_size} = {3'b111, 2'h3, 4'hA, 3'h2};
		{seg_reg, index_reg_operand, no_index, base_reg_operand, no_base, second_reg_operand,
			smi_after_io} = {3'h5, 4'h9, 1'b0, 4'hC, 1'b1, 4'hE, 1'b1};
		do_exit;
		rd(4'h4, 64'hF);
		rd(4'h5, 64'hFEDCBA9876543210);
		rd(4'h6, 64'hEE268153);
		for (int i = 0; i < 4; i++) rd(4'h7 + i[3:0], snap[i]);
		rd(4'hB, 64'hC);
		wr_strobe = 1'b1;
		@(negedge clk);
		wr_strobe = 1'b0;
		chk({63'h0, wr_fail_ff}, 64'h1);
		rd(4'h6, 64'hEE268153);
		complete_run;
	end
endmodule
`default_nettype wire
